// ---- common/mfw_consts.vh ----
`ifndef MFW_CONSTS_VH
`define MFW_CONSTS_VH
`define MFW_ADDR_MODE_CTRL 8'h00
`define MFW_ADDR_DEVICE_STATUS_REG 8'h04
`define MFW_ADDR_WAKE_STATUS_REG 8'h08
`define MFW_ADDR_WK_CTRL 8'h0c
`define MFW_ADDR_TIMER_CTRL 8'h10
`define MFW_ADDR_HIGH_SIDE_CONTROL_REG 8'h14
`define MFW_ADDR_WATCHDOG_CONTROL_REG 8'h18
`define MFW_ADDR_FAULT_STAT 8'h1c
`define MFW_MODE_RESTART 3'h0
`define MFW_MODE_NORMAL 3'h1
`define MFW_MODE_STOP 3'h2
`define MFW_MODE_SLEEP 3'h3
`define MFW_MODE_FAILSAFE 3'h4
`define MFW_REQ_NORMAL 2'h0
`define MFW_REQ_STOP 2'h1
`define MFW_REQ_SLEEP 2'h2
`define MFW_ON_OFF0 3'h0
`define MFW_ON_OFF6 3'h6
`define MFW_ON_OFF7 3'h7
`define MFW_WD_PER_RST 3'h4
`define MFW_FAIL_COUNT 3'h4
`define MFW_CLK_NS 8
`define MFW_T_RESTART_NS 10000
`define MFW_RESTART_CYC (`MFW_T_RESTART_NS / `MFW_CLK_NS)
`define MFW_T_INT_NS 1000
`define MFW_INT_CYC (`MFW_T_INT_NS / `MFW_CLK_NS)
`define MFW_T_SEVERE_THERMAL_SHUTDOWN_NS 1000000
`define MFW_SEVERE_THERMAL_SHUTDOWN_CYC (`MFW_T_SEVERE_THERMAL_SHUTDOWN_NS / `MFW_CLK_NS)
`define MFW_T_TICK_NS 100000
`define MFW_TICK_CYC (`MFW_T_TICK_NS / `MFW_CLK_NS)
`endif

// ---- verilog/mfw_cyc_timer.v ----
`timescale 1ns/100ps
`include "mfw_consts.vh"

module mfw_cyc_timer (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire tick,
    input wire run,
    input wire [2:0] period_code,
    input wire [2:0] on_code,
    // Phase outputs
    output reg on_q,
    output reg start_q,
    output reg end_q
);
    reg [15:0] cnt_q;
    reg first_q;
    wire [15:0] per_ticks = 16'h0008 << period_code;
    wire [15:0] on_ticks = {13'h0000, on_code};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            on_q <= 1'b0;
            start_q <= 1'b0;
            end_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
            end_q <= 1'b0;
            if (!run) begin
                cnt_q <= 16'h0000;
                on_q <= 1'b0;
                first_q <= 1'b1;
            end else if (tick) begin
                if (cnt_q == 16'h0000) begin
                    on_q <= 1'b1;
                    start_q <= ~first_q;
                    first_q <= 1'b0;
                end
                if (cnt_q == on_ticks) begin
                    on_q <= 1'b0;
                    end_q <= 1'b1;
                end
                if (cnt_q + 16'h0001 >= per_ticks) begin
                    cnt_q <= 16'h0000;
                    // An on-time longer than the period still ends the phase at wrap.
                    if (on_ticks > per_ticks) begin
                        on_q <= 1'b0;
                        end_q <= 1'b1;
                    end
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end
    end
endmodule // mfw_cyc_timer

// ---- verilog/mfw_sequencer.v ----
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "mfw_consts.vh"

module mfw_sequencer #(
    parameter SEVERE_THERMAL_SHUTDOWN_CYC = `MFW_SEVERE_THERMAL_SHUTDOWN_CYC,
    parameter TICK_CYC = `MFW_TICK_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Supply, thermal and watchdog events
    input wire main_reg_uv,
    input wire main_reg_ov,
    input wire main_reg_short,
    input wire severe_thermal_shutdown,
    input wire wd_trigger_fail,
    input wire wd_trigger_ok,
    // Wake sources
    input wire [3:0] wake_input_pins,
    input wire sync_wake_pin,
    input wire can_wake,
    input wire lin_wake,
    input wire ls_short_brake,
    // Peripheral failures
    input wire can_fail,
    input wire lin_fail,
    input wire bridge_fail,
    input wire [3:0] hs_fault,
    // Device pins and status
    output reg system_reset_output_n,
    output reg interrupt_output_pin_n,
    output reg shared_fail_wake_pin_o,
    output reg shared_fail_wake_pin_oe,
    output reg [3:0] high_side_switches,
    output reg wd_long_window,
    output reg [2:0] device_mode
);
    reg [2:0] mode_q;
    reg ov_sel_q, fo_cfg_q, failure_q, cmd_fault_q;
    reg [2:0] wd_cnt_q, uv_cnt_q, wd_per_q;
    reg [3:0] wk_flag_q, wk_en_q, cyc_sel_q, wk_prev_q, wk_lvl_q, fault_q, fault_mask_q;
    reg tmr_flag_q, can_wu_q, lin_wu_q, drain_source_overvoltage_status_q, can_en_q, lin_en_q;
    reg [2:0] per_code_q, on_code_q;
    reg cw_sel_q, sync_sel_q, sync_s_q;
    reg [7:0] high_side_control_reg_q;
    reg [15:0] rst_cnt_q, int_cnt_q, tick_cnt_q;
    reg [19:0] tsd_cnt_q;
    reg tsd_prev_q;
    reg [31:0] rd_d;
    reg rd_err;
    reg [2:0] mode_d;
    wire tmr_on, tmr_start, tmr_end;
    integer k;
    localparam RESTART_CYC = `MFW_RESTART_CYC;
    localparam INT_CYC = `MFW_INT_CYC;

    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire wr_mode = wr & (paddr == `MFW_ADDR_MODE_CTRL);
    wire wr_dev = wr & (paddr == `MFW_ADDR_DEVICE_STATUS_REG);
    wire wr_wks = wr & (paddr == `MFW_ADDR_WAKE_STATUS_REG);
    wire wr_fault = wr & (paddr == `MFW_ADDR_FAULT_STAT);
    wire [1:0] req = pwdata[1:0];

    wire in_rst = (mode_q == `MFW_MODE_RESTART);
    wire in_ns = (mode_q == `MFW_MODE_NORMAL) | (mode_q == `MFW_MODE_STOP);
    wire in_sleep = (mode_q == `MFW_MODE_SLEEP);
    wire in_fs = (mode_q == `MFW_MODE_FAILSAFE);

    // Timer tick prescaler.
    wire tick = (tick_cnt_q == TICK_CYC[15:0] - 16'h0001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        end
    end

    wire tmr_run = (on_code_q != `MFW_ON_OFF0) & (on_code_q != `MFW_ON_OFF6) &
        (on_code_q != `MFW_ON_OFF7);
    wire sense_run = tmr_run & ~cw_sel_q;
    wire cw_run = tmr_run & cw_sel_q;

    mfw_cyc_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .run(tmr_run),
        .period_code(per_code_q),
        .on_code(on_code_q),
        .on_q(tmr_on),
        .start_q(tmr_start),
        .end_q(tmr_end)
    );

    // With the sync source the pin itself frames the on-time.
    wire on_phase = sync_sel_q ? sync_s_q : tmr_on;
    wire samp = sense_run & (sync_sel_q ? (sync_s_q & ~sync_wake_pin) : tmr_end);
    wire [3:0] cyc_eff = cyc_sel_q & {4{sense_run & ~in_fs}};
    wire [3:0] stat_ev = wk_en_q & ~cyc_sel_q & (wake_input_pins ^ wk_prev_q);
    wire [3:0] fs_ev = wk_en_q & (wake_input_pins ^ wk_prev_q);
    wire [3:0] cyc_ev = wk_en_q & cyc_eff & (wake_input_pins ^ wk_lvl_q) & {4{samp}};
    wire [3:0] wk_ev = in_fs ? fs_ev : (stat_ev | cyc_ev);
    wire cw_ev = cw_run & tmr_start;
    wire [3:0] flt_ev = {hs_fault != 4'h0, bridge_fail, lin_fail, can_fail};

    wire wake_any = (wk_ev != 4'h0) | cw_ev | (can_wake & can_en_q) | (lin_wake & lin_en_q) | ls_short_brake;
    wire int_ev = in_ns & (wake_any | ((flt_ev & ~fault_mask_q) != 4'h0));
    wire no_src = (wk_en_q == 4'h0) & ~can_en_q & ~lin_en_q & ~cw_run;
    wire flags_set = (wk_flag_q != 4'h0) | tmr_flag_q | can_wu_q | lin_wu_q | drain_source_overvoltage_status_q;
    wire tsd_done = (tsd_cnt_q == SEVERE_THERMAL_SHUTDOWN_CYC[19:0]);
    wire wd_four = wd_trigger_fail & (wd_cnt_q + 3'h1 == `MFW_FAIL_COUNT);
    wire uv_four = main_reg_uv & (uv_cnt_q + 3'h1 == `MFW_FAIL_COUNT);
    wire to_fs = severe_thermal_shutdown | main_reg_short | (main_reg_ov & ov_sel_q) |
        (in_ns & (wd_four | uv_four));
    wire enter_fs = to_fs & ~in_fs;
    wire rst_done = (rst_cnt_q == RESTART_CYC[15:0] - 16'h0001);

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            `MFW_MODE_RESTART: begin
                if (rst_done) mode_d = `MFW_MODE_NORMAL;
            end
            `MFW_MODE_NORMAL, `MFW_MODE_STOP: begin
                if (main_reg_uv | wd_trigger_fail | (main_reg_ov & ~ov_sel_q)) begin
                    mode_d = `MFW_MODE_RESTART;
                end else if (wr_mode && req == `MFW_REQ_SLEEP) begin
                    if (no_src || flags_set || mode_q == `MFW_MODE_STOP) begin
                        mode_d = `MFW_MODE_RESTART;
                    end else begin
                        mode_d = `MFW_MODE_SLEEP;
                    end
                end else if (wr_mode && req == `MFW_REQ_STOP) begin
                    mode_d = `MFW_MODE_STOP;
                end else if (wr_mode && req == `MFW_REQ_NORMAL) begin
                    mode_d = `MFW_MODE_NORMAL;
                end
            end
            `MFW_MODE_SLEEP: begin
                if (wake_any || main_reg_uv || (main_reg_ov & ~ov_sel_q)) mode_d = `MFW_MODE_RESTART;
            end
            `MFW_MODE_FAILSAFE: begin
                if ((wk_ev != 4'h0) | can_wake | lin_wake | tsd_done | ls_short_brake) begin
                    mode_d = `MFW_MODE_RESTART;
                end
            end
            default: mode_d = `MFW_MODE_RESTART;
        endcase
        if (to_fs) mode_d = `MFW_MODE_FAILSAFE;
    end

    // Mode, restart timing and pins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `MFW_MODE_RESTART;
            rst_cnt_q <= 16'h0000;
            system_reset_output_n <= 1'b0;
            wd_long_window <= 1'b0;
            int_cnt_q <= 16'h0000;
            interrupt_output_pin_n <= 1'b1;
            tsd_cnt_q <= 20'h00000;
            tsd_prev_q <= 1'b0;
            sync_s_q <= 1'b0;
            shared_fail_wake_pin_o <= 1'b1;
            shared_fail_wake_pin_oe <= 1'b0;
            device_mode <= `MFW_MODE_RESTART;
        end else begin
            mode_q <= mode_d;
            device_mode <= mode_d;
            rst_cnt_q <= (in_rst && !rst_done) ? rst_cnt_q + 16'h0001 : 16'h0000;
            system_reset_output_n <= (mode_d != `MFW_MODE_RESTART) & (mode_d != `MFW_MODE_SLEEP) &
                (mode_d != `MFW_MODE_FAILSAFE);
            wd_long_window <= in_rst & rst_done;
            if (int_ev) begin
                int_cnt_q <= INT_CYC[15:0];
            end else if (int_cnt_q != 16'h0000) begin
                int_cnt_q <= int_cnt_q - 16'h0001;
            end
            interrupt_output_pin_n <= ~(int_ev | (int_cnt_q > 16'h0001));
            // The release delay only runs once the hot condition has gone.
            tsd_prev_q <= severe_thermal_shutdown;
            if (!in_fs || severe_thermal_shutdown || tsd_done) begin
                tsd_cnt_q <= 20'h00000;
            end else if (tsd_prev_q || tsd_cnt_q != 20'h00000) begin
                tsd_cnt_q <= tsd_cnt_q + 20'h00001;
            end
            sync_s_q <= sync_wake_pin;
            shared_fail_wake_pin_o <= 1'b0;
            // The leaving cycle keeps the pin driven until the failure flag has been set.
            shared_fail_wake_pin_oe <= fo_cfg_q & ((mode_d == `MFW_MODE_FAILSAFE) | in_fs | failure_q);
        end
    end

    // Per-switch drive and per-input level status.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            wire [1:0] hm = high_side_control_reg_q[2*g+1:2*g];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    high_side_switches[g] <= 1'b0;
                    wk_lvl_q[g] <= 1'b0;
                end else begin
                    if (!hm[1]) begin
                        high_side_switches[g] <= hm[0];
                    end else begin
                        high_side_switches[g] <= sense_run ? on_phase : hm[0];
                    end
                    if (!cyc_eff[g] || samp) begin
                        wk_lvl_q[g] <= wake_input_pins[g];
                    end
                end
            end
        end
    endgenerate

    // Registers written by software and set by hardware.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_sel_q <= 1'b0;
            fo_cfg_q <= 1'b0;
            failure_q <= 1'b0;
            cmd_fault_q <= 1'b0;
            wd_cnt_q <= 3'h0;
            uv_cnt_q <= 3'h0;
            wd_per_q <= `MFW_WD_PER_RST;
            wk_flag_q <= 4'h0;
            wk_en_q <= 4'h0;
            cyc_sel_q <= 4'h0;
            wk_prev_q <= 4'h0;
            fault_q <= 4'h0;
            fault_mask_q <= 4'h0;
            tmr_flag_q <= 1'b0;
            can_wu_q <= 1'b0;
            lin_wu_q <= 1'b0;
            drain_source_overvoltage_status_q <= 1'b0;
            can_en_q <= 1'b0;
            lin_en_q <= 1'b0;
            per_code_q <= 3'h0;
            on_code_q <= 3'h0;
            cw_sel_q <= 1'b0;
            sync_sel_q <= 1'b0;
            high_side_control_reg_q <= 8'h00;
        end else begin
            wk_prev_q <= wake_input_pins;
            if (wr) begin
                case (paddr)
                    `MFW_ADDR_MODE_CTRL: {fo_cfg_q, ov_sel_q} <= pwdata[3:2];
                    `MFW_ADDR_WK_CTRL: {lin_en_q, can_en_q, cyc_sel_q, wk_en_q} <= pwdata[9:0];
                    `MFW_ADDR_TIMER_CTRL: {sync_sel_q, cw_sel_q, on_code_q, per_code_q} <= {pwdata[9:8],
                        pwdata[6:4], pwdata[2:0]};
                    `MFW_ADDR_HIGH_SIDE_CONTROL_REG: high_side_control_reg_q <= pwdata[7:0];
                    `MFW_ADDR_WATCHDOG_CONTROL_REG: wd_per_q <= pwdata[2:0];
                    `MFW_ADDR_FAULT_STAT: fault_mask_q <= pwdata[11:8];
                    default: ;
                endcase
            end
            if (in_rst & rst_done) wd_per_q <= `MFW_WD_PER_RST;
            // A hardware set in the same cycle as a clear always wins.
            failure_q <= (failure_q & ~(wr_dev & pwdata[3])) | (in_fs & (mode_d != `MFW_MODE_FAILSAFE));
            cmd_fault_q <= (cmd_fault_q & ~(wr_dev & pwdata[4])) |
                (tmr_run & ({13'h0000, on_code_q} > (16'h0008 << per_code_q)));
            wk_flag_q <= (wk_flag_q & ~({4{wr_wks}} & pwdata[3:0])) | wk_ev;
            tmr_flag_q <= (tmr_flag_q & ~(wr_wks & pwdata[4])) | cw_ev;
            can_wu_q <= (can_wu_q & ~(wr_wks & pwdata[5])) | (can_wake & (can_en_q | in_fs));
            lin_wu_q <= (lin_wu_q & ~(wr_wks & pwdata[6])) | (lin_wake & (lin_en_q | in_fs));
            drain_source_overvoltage_status_q <= (drain_source_overvoltage_status_q & ~(wr_wks & pwdata[7])) | ls_short_brake;
            fault_q <= (fault_q & ~({4{wr_fault}} & pwdata[3:0])) | flt_ev;
            if (wd_trigger_ok) begin
                wd_cnt_q <= 3'h0;
                uv_cnt_q <= 3'h0;
            end else begin
                if (wd_trigger_fail && in_ns && wd_cnt_q != `MFW_FAIL_COUNT) wd_cnt_q <= wd_cnt_q + 3'h1;
                if (main_reg_uv && in_ns && uv_cnt_q != `MFW_FAIL_COUNT) uv_cnt_q <= uv_cnt_q + 3'h1;
            end
            for (k = 0; k < 4; k = k + 1) begin
                if (hs_fault[k]) high_side_control_reg_q[2*k+1 -: 2] <= 2'h0;
            end
            if (enter_fs) begin
                on_code_q <= `MFW_ON_OFF0;
                for (k = 0; k < 4; k = k + 1) begin
                    if (high_side_control_reg_q[2*k+1]) high_side_control_reg_q[2*k+1 -: 2] <= 2'h0;
                end
            end
        end
    end

    // Read mux and APB answer, one wait state per transfer.
    always @* begin
        rd_d = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `MFW_ADDR_MODE_CTRL: rd_d[3:2] = {fo_cfg_q, ov_sel_q};
            `MFW_ADDR_DEVICE_STATUS_REG: rd_d[10:0] = {uv_cnt_q, wd_cnt_q, cmd_fault_q, failure_q, mode_q};
            `MFW_ADDR_WAKE_STATUS_REG: rd_d[11:0] = {wk_lvl_q, drain_source_overvoltage_status_q, lin_wu_q, can_wu_q, tmr_flag_q, wk_flag_q};
            `MFW_ADDR_WK_CTRL: rd_d[9:0] = {lin_en_q, can_en_q, cyc_sel_q, wk_en_q};
            `MFW_ADDR_TIMER_CTRL: rd_d[9:0] = {sync_sel_q, cw_sel_q, 1'b0, on_code_q, 1'b0, per_code_q};
            `MFW_ADDR_HIGH_SIDE_CONTROL_REG: rd_d[7:0] = high_side_control_reg_q;
            `MFW_ADDR_WATCHDOG_CONTROL_REG: rd_d[2:0] = wd_per_q;
            `MFW_ADDR_FAULT_STAT: rd_d[11:0] = {fault_mask_q, 4'h0, fault_q};
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & rd_err;
            if (psel & penable & ~pready & ~pwrite) prdata <= rd_d;
        end
    end
endmodule // mfw_sequencer

// ---- sim/mfw_seq_sva.sv ----
`timescale 1ns/100ps
`include "mfw_consts.vh"
module mfw_seq_sva (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    // Events
    input wire main_reg_uv,
    input wire main_reg_ov,
    input wire main_reg_short,
    input wire severe_thermal_shutdown,
    input wire wd_trigger_fail,
    input wire ls_short_brake,
    input wire can_fail,
    input wire lin_fail,
    input wire bridge_fail,
    input wire [3:0] hs_fault,
    // Device pins
    input wire system_reset_output_n,
    input wire interrupt_output_pin_n,
    input wire shared_fail_wake_pin_oe,
    input wire wd_long_window,
    input wire [2:0] device_mode
);
    logic [10:0] rcnt_q;
    wire crit = main_reg_short | severe_thermal_shutdown;
    wire fails = can_fail | lin_fail | bridge_fail | (|hs_fault);
    wire mode_ev = main_reg_uv | main_reg_ov | crit | wd_trigger_fail;
    wire dev_clr = psel & penable & pready & pwrite & (paddr == `MFW_ADDR_DEVICE_STATUS_REG);
    wire in_run = (device_mode == `MFW_MODE_NORMAL) | (device_mode == `MFW_MODE_STOP);
    // A counter bounds the restart stay, which is too long for a delay range.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_q <= 11'h0;
        end else if (device_mode == `MFW_MODE_RESTART) begin
            rcnt_q <= rcnt_q + 11'h1;
        end else begin
            rcnt_q <= 11'h0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_left_restart; $past(device_mode) == `MFW_MODE_RESTART && device_mode != `MFW_MODE_RESTART; endsequence
    sequence s_wd_pulse; wd_long_window ##1 !wd_long_window; endsequence
    property p_restart_len; rcnt_q <= 11'h4e3; endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart stay too long");
    property p_auto_normal; s_left_restart |-> device_mode == `MFW_MODE_NORMAL && system_reset_output_n; endproperty
    a_auto_normal: assert property (p_auto_normal) else $error("restart did not lead to normal");
    property p_rst_low; device_mode == `MFW_MODE_RESTART |-> !system_reset_output_n; endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset output high in restart");
    property p_wd_window; $rose(system_reset_output_n) |-> s_wd_pulse; endproperty
    a_wd_window: assert property (p_wd_window) else $error("no long window pulse at reset release");
    property p_stay; device_mode == `MFW_MODE_NORMAL && fails && !mode_ev |=> device_mode == `MFW_MODE_NORMAL; endproperty
    a_stay: assert property (p_stay) else $error("peripheral failure changed mode");
    property p_uv; device_mode == `MFW_MODE_NORMAL && main_reg_uv && !crit |=> device_mode inside {3'h0, 3'h4}; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage did not restart");
    property p_fs_entry; in_run && crit |=> device_mode == `MFW_MODE_FAILSAFE; endproperty
    a_fs_entry: assert property (p_fs_entry) else $error("critical event missed fail-safe");
    property p_fs_exit; device_mode == `MFW_MODE_FAILSAFE && ls_short_brake && !crit |=> device_mode == 3'h0; endproperty
    a_fs_exit: assert property (p_fs_exit) else $error("fail-safe wake did not restart");
    property p_fo_only; $rose(shared_fail_wake_pin_oe) |-> device_mode == `MFW_MODE_FAILSAFE; endproperty
    a_fo_only: assert property (p_fo_only) else $error("fail output outside fail-safe");
    property p_fo_rel; $fell(shared_fail_wake_pin_oe) |-> $past(dev_clr) || $past(dev_clr, 2); endproperty
    a_fo_rel: assert property (p_fo_rel) else $error("fail output released without clear");
    property p_int_mode; $fell(interrupt_output_pin_n) |-> in_run; endproperty
    a_int_mode: assert property (p_int_mode) else $error("interrupt outside normal or stop");
endmodule // mfw_seq_sva

bind mfw_sequencer mfw_seq_sva i_sva (.*);

// ---- sim/mfw_host_model.sv ----
`timescale 1ns/100ps
module mfw_host_model (
    // Clock
    input wire pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire pready,
    // Interrupt line
    input wire interrupt_output_pin_n
);
    int int_cnt = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Falls are counted since one low pulse may cover several close events.
    always @(negedge interrupt_output_pin_n) int_cnt++;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // mfw_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`include "mfw_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic pclk, presetn, tsd, shrt, psel, penable, pwrite, pready, pslverr, rst_n, int_n, fo_oe, wdw;
    logic [13:0] ev;
    logic [3:0] wk, hs;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] device_mode;
    logic [32:0] exp_q[$], msk_q[$], e, m;
    int err_total = 0;
    int total_checks = 0;
    int c, on;
    int dis[3] = '{0, 6, 7};
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    mfw_sequencer #(.SEVERE_THERMAL_SHUTDOWN_CYC(50), .TICK_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_reg_uv(ev[0]), .main_reg_ov(ev[1]), .main_reg_short(shrt),
        .severe_thermal_shutdown(tsd), .wd_trigger_fail(ev[2]), .wd_trigger_ok(ev[3]), .wake_input_pins(wk),
        .sync_wake_pin(1'b0), .can_wake(ev[4]), .lin_wake(ev[5]), .ls_short_brake(ev[6]), .can_fail(ev[7]),
        .lin_fail(ev[8]), .bridge_fail(ev[9]), .hs_fault(ev[13:10]), .system_reset_output_n(rst_n),
        .interrupt_output_pin_n(int_n), .shared_fail_wake_pin_o(), .shared_fail_wake_pin_oe(fo_oe),
        .high_side_switches(hs), .wd_long_window(wdw), .device_mode(device_mode));
    mfw_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .interrupt_output_pin_n(int_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev <= 14'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [31:0] mk);
        exp_q.push_back(x);
        msk_q.push_back({1'b1, mk});
        i_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wmode(input logic [2:0] md, input int lim);
        for (int i = 0; i < lim && device_mode !== md; i++) @(posedge pclk);
        #1;
        `CHK(device_mode, md)
    endtask
    task automatic back();
        wmode(`MFW_MODE_NORMAL, 1400);
        pulse(3);
        wr(`MFW_ADDR_DEVICE_STATUS_REG, 32'h18);
        wr(`MFW_ADDR_WAKE_STATUS_REG, 32'hff);
    endtask
    task close_out();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK({pslverr, prdata} & m, e)
        end
    end
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        tsd = 1'b0;
        shrt = 1'b0;
        ev = 14'h0;
        c = $urandom(93897);
        wk = $urandom;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cyc(1200);
        `CHK(device_mode, `MFW_MODE_RESTART)
        `CHK(rst_n, 1'b0)
        back();
        `CHK(rst_n, 1'b1)
        wr(`MFW_ADDR_WATCHDOG_CONTROL_REG, 32'h1);
        rd(`MFW_ADDR_WATCHDOG_CONTROL_REG, 33'h1, 32'h7);
        rd(8'h20, 33'h100000000, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            c = i_host.int_cnt;
            pulse((i < 3) ? 7 + i : 10 + $urandom % 4);
            cyc(130);
            `CHK(device_mode, `MFW_MODE_NORMAL)
            `CHK(i_host.int_cnt - c, 1)
        end
        rd(`MFW_ADDR_FAULT_STAT, 33'hf, 32'hf);
        wr(`MFW_ADDR_FAULT_STAT, 32'hf0f);
        c = i_host.int_cnt;
        pulse(7);
        cyc(20);
        `CHK(i_host.int_cnt - c, 0)
        wr(`MFW_ADDR_FAULT_STAT, 32'h0);
        wr(`MFW_ADDR_MODE_CTRL, 32'hb);
        for (int k = 1; k < 5; k++) begin
            pulse(0);
            cyc(2);
            `CHK(device_mode, (k < 4) ? `MFW_MODE_RESTART : `MFW_MODE_FAILSAFE)
            if (k < 4) begin
                wmode(`MFW_MODE_NORMAL, 1400);
                rd(`MFW_ADDR_DEVICE_STATUS_REG, 33'(k << 8), 32'h700);
                rd(`MFW_ADDR_WATCHDOG_CONTROL_REG, 33'h4, 32'h7);
            end
        end
        pulse(6);
        wmode(`MFW_MODE_RESTART, 20);
        back();
        for (int i = 0; i < 5; i++) begin
            wr(`MFW_ADDR_MODE_CTRL, (i == 1) ? 32'h3 : (i == 2) ? 32'hf : 32'hb);
            if (i == 0) tsd <= 1'b1;
            else if (i == 1) shrt <= 1'b1;
            else pulse((i == 4) ? 2 : 1);
            cyc(2);
            `CHK(device_mode, (i < 3) ? `MFW_MODE_FAILSAFE : `MFW_MODE_RESTART)
            if (i < 3) begin
                `CHK(fo_oe, (i != 1))
                @(posedge pclk);
                tsd <= 1'b0;
                shrt <= 1'b0;
                if (i == 0) cyc(40);
                `CHK(device_mode, `MFW_MODE_FAILSAFE)
                if (i > 0) pulse(6);
                wmode(`MFW_MODE_RESTART, 40);
                rd(`MFW_ADDR_DEVICE_STATUS_REG, 33'h8, 32'h8);
                `CHK(fo_oe, (i != 1))
            end
            back();
            `CHK(fo_oe, 1'b0)
        end
        wr(`MFW_ADDR_WK_CTRL, 32'h0);
        on = 1 + $urandom % 5;
        c = i_host.int_cnt;
        wr(`MFW_ADDR_TIMER_CTRL, 32'h103 | (on << 4));
        cyc(200);
        `CHK(i_host.int_cnt - c, 0)
        cyc(120);
        `CHK(i_host.int_cnt - c, 1)
        for (int j = 0; j < 3; j++) begin
            wr(`MFW_ADDR_TIMER_CTRL, 32'h103 | (dis[j] << 4));
            c = i_host.int_cnt;
            cyc(600);
            `CHK(i_host.int_cnt - c, 0)
        end
        wr(`MFW_ADDR_WAKE_STATUS_REG, 32'hff);
        wr(`MFW_ADDR_TIMER_CTRL, 32'h113);
        wr(`MFW_ADDR_MODE_CTRL, 32'h2);
        cyc(2);
        `CHK(device_mode, `MFW_MODE_SLEEP)
        wmode(`MFW_MODE_RESTART, 600);
        back();
        wr(`MFW_ADDR_TIMER_CTRL, 32'h0);
        wr(`MFW_ADDR_WK_CTRL, 32'h100);
        wr(`MFW_ADDR_WAKE_STATUS_REG, 32'hff);
        pulse(6);
        wr(`MFW_ADDR_MODE_CTRL, 32'h2);
        wmode(`MFW_MODE_RESTART, 20);
        back();
        wr(`MFW_ADDR_WK_CTRL, 32'h0);
        wr(`MFW_ADDR_MODE_CTRL, 32'h2);
        wmode(`MFW_MODE_RESTART, 20);
        back();
        wr(`MFW_ADDR_HIGH_SIDE_CONTROL_REG, 32'h3);
        wr(`MFW_ADDR_WK_CTRL, 32'h11);
        `CHK(hs[0], 1'b1)
        c = i_host.int_cnt;
        wr(`MFW_ADDR_TIMER_CTRL, 32'h13);
        wk[0] <= ~wk[0];
        cyc(300);
        `CHK(i_host.int_cnt - c, 1)
        rd(`MFW_ADDR_WAKE_STATUS_REG, {wk[0], 8'h01}, 32'h101);
        close_out();
    end
endmodule // tb_top
